// >>> hdl/jrle_regs.svh
// Constants for the relative-jump and move execution block
`ifndef JRLE_REGS_SVH
`define JRLE_REGS_SVH
// Opcode low nibbles and full opcodes
`define JRLE_NIB_JUMP 4'hB
`define JRLE_NIB_LD_IMM 4'hC
`define JRLE_NIB_LD_R2W 4'h8
`define JRLE_NIB_LD_W2R 4'h9
`define JRLE_OP_LD_WIW 8'hE3
`define JRLE_OP_LD_IWW 8'hF3
`define JRLE_OP_LD_RR 8'hE4
`define JRLE_OP_LD_RIR 8'hE5
`define JRLE_OP_LD_RIM 8'hE6
`define JRLE_OP_LD_IRIM 8'hE7
`define JRLE_OP_LD_IRR 8'hF5
`define JRLE_OP_LD_XLD 8'hC7
`define JRLE_OP_LD_XST 8'hD7
`define JRLE_OP_PM_LD 8'hC2
`define JRLE_OP_PM_ST 8'hD2
`define JRLE_OP_PMB_LD 8'hC3
`define JRLE_OP_PMB_ST 8'hD3
`define JRLE_OP_XD_LD 8'h82
`define JRLE_OP_XD_ST 8'h92
// Working-register escape nibble and always-true and never-true conditions
`define JRLE_WR_ESC 4'hE
`define JRLE_CC_ALWAYS 4'h8
`define JRLE_CC_NEVER 4'h0
// Flag bit positions in the flag byte
`define JRLE_FLAG_C 7
`define JRLE_FLAG_Z 6
`define JRLE_FLAG_S 5
`define JRLE_FLAG_V 4
// Cycle budgets
`define JRLE_CYC_JR_TAKEN 8'd12
`define JRLE_CYC_JR_NOT 8'd10
`define JRLE_CYC_SHORT 8'd6
`define JRLE_CYC_LONG 8'd10
`define JRLE_CYC_PM 8'd12
`define JRLE_CYC_PMB 8'd18
`define JRLE_CYC_XD 8'd12
`endif

// >>> hdl/jrle_pkg.sv
// Types for the relative-jump and move execution block
package jrle_pkg;
	typedef logic [7:0] jrle_byte_t;
	typedef logic [15:0] jrle_addr_t;
	typedef enum logic [1:0] {jrle_mem_none, jrle_mem_prog, jrle_mem_data} jrle_mem_e;
endpackage

// >>> hdl/jrle_cond.sv
// Condition-field evaluator for the relative jump
`timescale 1ns/1ps
`default_nettype none
`include "jrle_regs.svh"
module jrle_cond
(
	// Condition and flags
	input wire logic [3:0] condition_field,
	input wire logic [7:0] flags,
	// Result
	output logic cond_true
);
	logic c;
	logic z;
	logic s;
	logic v;
	logic base;
	assign c = flags[`JRLE_FLAG_C];
	assign z = flags[`JRLE_FLAG_Z];
	assign s = flags[`JRLE_FLAG_S];
	assign v = flags[`JRLE_FLAG_V];
	// Upper half of the codes is the complement of the lower half
	always_comb
	begin
		unique case (condition_field[2:0])
			3'h0: base = 1'b0;
			3'h1: base = s ^ v;
			3'h2: base = z | (s ^ v);
			3'h3: base = c | z;
			3'h4: base = v;
			3'h5: base = s;
			3'h6: base = z;
			3'h7: base = c;
		endcase
	end
	assign cond_true = base ^ condition_field[3]; // [RULE4]
endmodule
`default_nettype wire

// >>> hdl/jrle_exec.sv
// Execution of relative jumps and byte, program and external moves
// Function
// RULE1 - True condition adds displacement to PC, else fall through
// RULE2 - Displacement is a signed byte, range -128 to +127
// RULE3 - Displacement is added to the address after the two-byte jump
// RULE4 - Unconditional condition code always takes the jump
// RULE5 - Moves copy source to destination, source left unchanged
// RULE6 - Working-to-register short move uses a full 8-bit destination
// RULE7 - Operand with high nibble 1110 selects a working register
// RULE8 - Indexed moves add base to index register, index unchanged
// RULE9 - Program-memory move, either direction, via pointer pair, 12 cycles
// RULE10 - Program-memory writes only on external-program variants
// RULE11 - Block move increments pointer register and pair, 18 cycles
// RULE12 - Block move direction chosen by opcode
// RULE13 - External-data move, either direction, via pointer pair
// RULE14 - External-data moves only on external-data variants
// RULE15 - No instruction here alters the flag register
// RULE16 - Pointer pair: even register high byte, odd register low byte
`timescale 1ns/1ps
`default_nettype none
`include "jrle_regs.svh"
module jrle_exec
	import jrle_pkg::*;
#(
	parameter bit HAS_EXT_PROG = 1'b1,
	parameter bit HAS_EXT_DATA = 1'b1
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clk_en,
	// Instruction from decode; pc is the address after the instruction
	input wire logic instr_valid,
	input wire jrle_pkg::jrle_byte_t opcode,
	input wire jrle_pkg::jrle_byte_t operand1,
	input wire jrle_pkg::jrle_byte_t operand2,
	input wire jrle_pkg::jrle_addr_t pc,
	input wire jrle_pkg::jrle_byte_t flags,
	input wire logic [3:0] wr_group,
	// Register file, combinational read
	output jrle_pkg::jrle_byte_t rf_raddr,
	input wire jrle_pkg::jrle_byte_t rf_rdata,
	output logic rf_we,
	output jrle_pkg::jrle_byte_t rf_waddr,
	output jrle_pkg::jrle_byte_t rf_wdata,
	// Program and external data memory
	output logic mem_req,
	output logic mem_we,
	output jrle_pkg::jrle_mem_e mem_space,
	output jrle_pkg::jrle_addr_t mem_addr,
	output jrle_pkg::jrle_byte_t mem_wdata,
	input wire logic mem_ack,
	input wire jrle_pkg::jrle_byte_t mem_rdata,
	// Completion
	output logic pc_load,
	output jrle_pkg::jrle_addr_t pc_next,
	output logic done,
	output logic illegal,
	output logic [7:0] cycles
);
	import jrle_pkg::*;

	typedef enum logic [3:0] {
		jrle_idle, jrle_rd1, jrle_rd2, jrle_rd3, jrle_rd4,
		jrle_mem, jrle_wr, jrle_inc_lo, jrle_inc_hi, jrle_inc_r
	} jrle_state_e;

	jrle_state_e state;
	jrle_byte_t op;
	jrle_byte_t a1;
	jrle_byte_t a2;
	jrle_byte_t t1;
	jrle_byte_t t2;
	jrle_byte_t t3;
	jrle_byte_t dst_addr;
	logic cond_true;

	// ==========================================================
	// Address helpers
	function automatic jrle_byte_t wreg(input logic [3:0] g, input logic [3:0] n);
		wreg = {g, n};
	endfunction

	// Map a full operand byte, escaping 1110 to a working register
	function automatic jrle_byte_t reg_full(input logic [3:0] g, input jrle_byte_t b);
		reg_full = (b[7:4] == `JRLE_WR_ESC) ? wreg(g, b[3:0]) : b; // [RULE7]
	endfunction

	// Even register of a pair; odd partner follows
	function automatic jrle_byte_t pair_hi(input logic [3:0] g, input logic [3:0] n);
		pair_hi = wreg(g, {n[3:1], 1'b0}); // [RULE16]
	endfunction

	jrle_cond u_cond
	(
		.condition_field(opcode[7:4]),
		.flags(flags),
		.cond_true(cond_true)
	);

	// ==========================================================
	// Sequencer; flags are never an output here [RULE15]
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			state <= jrle_idle;
			op <= 8'h00;
			a1 <= 8'h00;
			a2 <= 8'h00;
			t1 <= 8'h00;
			t2 <= 8'h00;
			t3 <= 8'h00;
			dst_addr <= 8'h00;
			rf_raddr <= 8'h00;
			rf_we <= 1'b0;
			rf_waddr <= 8'h00;
			rf_wdata <= 8'h00;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_space <= jrle_mem_none;
			mem_addr <= 16'h0000;
			mem_wdata <= 8'h00;
			pc_load <= 1'b0;
			pc_next <= 16'h0000;
			done <= 1'b0;
			illegal <= 1'b0;
			cycles <= 8'h00;
		end
		else if (clk_en)
		begin
			rf_we <= 1'b0;
			pc_load <= 1'b0;
			done <= 1'b0;
			illegal <= 1'b0;
			unique case (state)
				jrle_idle:
				begin
					if (instr_valid)
					begin
						op <= opcode;
						a1 <= operand1;
						a2 <= operand2;
						if (opcode[3:0] == `JRLE_NIB_JUMP)
						begin
							// pc already points past both bytes [RULE3]
							pc_next <= pc + {{8{operand1[7]}}, operand1}; // [RULE2]
							pc_load <= cond_true; // [RULE1] [RULE4]
							cycles <= cond_true ? `JRLE_CYC_JR_TAKEN : `JRLE_CYC_JR_NOT;
							done <= 1'b1;
						end
						else if (opcode[3:0] == `JRLE_NIB_LD_IMM)
						begin
							rf_we <= 1'b1;
							rf_waddr <= wreg(wr_group, opcode[7:4]);
							rf_wdata <= operand1;
							cycles <= `JRLE_CYC_SHORT;
							done <= 1'b1;
						end
						else if (opcode[3:0] == `JRLE_NIB_LD_R2W)
						begin
							rf_raddr <= reg_full(wr_group, operand1);
							dst_addr <= wreg(wr_group, opcode[7:4]);
							cycles <= `JRLE_CYC_SHORT;
							state <= jrle_wr;
						end
						else if (opcode[3:0] == `JRLE_NIB_LD_W2R)
						begin
							rf_raddr <= wreg(wr_group, opcode[7:4]);
							dst_addr <= operand1; // [RULE6]
							cycles <= `JRLE_CYC_SHORT;
							state <= jrle_wr;
						end
						else
						begin
							unique case (opcode)
								`JRLE_OP_LD_WIW, `JRLE_OP_LD_IWW:
								begin
									// Store form reads its pointer first
									rf_raddr <= wreg(wr_group,
										(opcode == `JRLE_OP_LD_IWW)
										? operand1[7:4] : operand1[3:0]);
									cycles <= `JRLE_CYC_SHORT;
									state <= jrle_rd1;
								end
								`JRLE_OP_LD_RR, `JRLE_OP_LD_RIR, `JRLE_OP_LD_IRIM,
								`JRLE_OP_LD_IRR:
								begin
									rf_raddr <= reg_full(wr_group, operand1);
									cycles <= `JRLE_CYC_LONG;
									state <= jrle_rd1;
								end
								`JRLE_OP_LD_RIM:
								begin
									rf_we <= 1'b1;
									rf_waddr <= reg_full(wr_group, operand1);
									rf_wdata <= operand2;
									cycles <= `JRLE_CYC_LONG;
									done <= 1'b1;
								end
								`JRLE_OP_LD_XLD, `JRLE_OP_LD_XST:
								begin
									rf_raddr <= wreg(wr_group, operand1[3:0]); // index
									cycles <= `JRLE_CYC_LONG;
									state <= jrle_rd1;
								end
								`JRLE_OP_PM_LD, `JRLE_OP_PM_ST, `JRLE_OP_PMB_LD,
								`JRLE_OP_PMB_ST, `JRLE_OP_XD_LD, `JRLE_OP_XD_ST:
								begin
									if (((opcode == `JRLE_OP_PM_ST || opcode == `JRLE_OP_PMB_ST)
										&& !HAS_EXT_PROG) // [RULE10]
										|| ((opcode == `JRLE_OP_XD_LD || opcode == `JRLE_OP_XD_ST)
										&& !HAS_EXT_DATA)) // [RULE14]
									begin
										illegal <= 1'b1;
										done <= 1'b1;
									end
									else
									begin
										rf_raddr <= pair_hi(wr_group, operand1[3:0]); // [RULE16]
										cycles <= (opcode[0]) ? `JRLE_CYC_PMB
											: (opcode == `JRLE_OP_XD_LD
											|| opcode == `JRLE_OP_XD_ST)
											? `JRLE_CYC_XD : `JRLE_CYC_PM; // [RULE9] [RULE11]
										state <= jrle_rd1;
									end
								end
								default:
								begin
									illegal <= 1'b1;
									done <= 1'b1;
								end
							endcase
						end
					end
				end
				jrle_rd1:
				begin
					t1 <= rf_rdata;
					unique case (op)
						`JRLE_OP_LD_WIW:
						begin
							rf_raddr <= rf_rdata;
							dst_addr <= wreg(wr_group, a1[7:4]);
							state <= jrle_wr;
						end
						`JRLE_OP_LD_IWW:
						begin
							dst_addr <= rf_rdata;
							rf_raddr <= wreg(wr_group, a1[3:0]);
							state <= jrle_wr;
						end
						`JRLE_OP_LD_RR:
						begin
							dst_addr <= reg_full(wr_group, a2);
							state <= jrle_wr;
							rf_raddr <= reg_full(wr_group, a1);
						end
						`JRLE_OP_LD_RIR:
						begin
							rf_raddr <= rf_rdata;
							dst_addr <= reg_full(wr_group, a2);
							state <= jrle_wr;
						end
						`JRLE_OP_LD_IRIM:
						begin
							rf_we <= 1'b1;
							rf_waddr <= rf_rdata;
							rf_wdata <= a2;
							done <= 1'b1;
							state <= jrle_idle;
						end
						`JRLE_OP_LD_IRR:
						begin
							// a1 is source register, a2 the pointer register
							t1 <= rf_rdata;
							rf_raddr <= reg_full(wr_group, a2);
							state <= jrle_rd2;
						end
						`JRLE_OP_LD_XLD, `JRLE_OP_LD_XST:
						begin
							// Index register only read, never written [RULE8]
							if (op == `JRLE_OP_LD_XLD)
							begin
								rf_raddr <= a2 + rf_rdata; // [RULE8]
								dst_addr <= wreg(wr_group, a1[7:4]);
							end
							else
							begin
								dst_addr <= a2 + rf_rdata; // [RULE8]
								rf_raddr <= wreg(wr_group, a1[7:4]);
							end
							state <= jrle_wr;
						end
						default:
						begin
							rf_raddr <= rf_raddr + 8'h01; // odd partner [RULE16]
							state <= jrle_rd2;
						end
					endcase
				end
				jrle_rd2:
				begin
					if (op == `JRLE_OP_LD_IRR)
					begin
						// Pointer value is the target; source read again
						rf_raddr <= reg_full(wr_group, a1);
						dst_addr <= rf_rdata;
						state <= jrle_wr;
					end
					else
					begin
						t2 <= rf_rdata;
						rf_raddr <= wreg(wr_group, a1[7:4]);
						state <= jrle_rd3;
					end
				end
				jrle_rd3:
				begin
					// t3 holds the dst/src working register value
					t3 <= rf_rdata;
					if (op[0])
					begin
						rf_raddr <= rf_rdata; // block move register-file pointer
						state <= jrle_rd4;
					end
					else
					begin
						mem_req <= 1'b1;
						mem_we <= op[4];
						mem_wdata <= rf_rdata;
						mem_addr <= {t1, t2}; // [RULE16]
						mem_space <= (op == `JRLE_OP_PM_LD || op == `JRLE_OP_PM_ST)
							? jrle_mem_prog : jrle_mem_data; // [RULE9] [RULE13]
						state <= jrle_mem;
					end
				end
				jrle_rd4:
				begin
					mem_req <= 1'b1;
					mem_we <= op[4]; // [RULE12]
					mem_wdata <= rf_rdata;
					mem_addr <= {t1, t2};
					mem_space <= jrle_mem_prog;
					state <= jrle_mem;
				end
				jrle_mem:
				begin
					if (mem_ack)
					begin
						mem_req <= 1'b0;
						mem_we <= 1'b0;
						mem_space <= jrle_mem_none;
						if (!op[4])
						begin
							rf_we <= 1'b1;
							rf_waddr <= op[0] ? t3 : wreg(wr_group, a1[7:4]); // [RULE12]
							rf_wdata <= mem_rdata;
						end
						if (op[0])
						begin
							{t1, t2} <= {t1, t2} + 16'h0001; // [RULE11]
							state <= jrle_inc_lo;
						end
						else
						begin
							done <= 1'b1;
							state <= jrle_idle;
						end
					end
				end
				jrle_inc_lo:
				begin
					rf_we <= 1'b1;
					rf_waddr <= pair_hi(wr_group, a1[3:0]) + 8'h01;
					rf_wdata <= t2; // [RULE11]
					state <= jrle_inc_hi;
				end
				jrle_inc_hi:
				begin
					rf_we <= 1'b1;
					rf_waddr <= pair_hi(wr_group, a1[3:0]);
					rf_wdata <= t1; // [RULE11]
					state <= jrle_inc_r;
				end
				jrle_inc_r:
				begin
					rf_we <= 1'b1;
					rf_waddr <= wreg(wr_group, a1[7:4]);
					rf_wdata <= t3 + 8'h01; // [RULE11]
					done <= 1'b1;
					state <= jrle_idle;
				end
				jrle_wr:
				begin
					// Only destination written; source left intact [RULE5]
					rf_we <= 1'b1;
					rf_waddr <= dst_addr;
					rf_wdata <= rf_rdata;
					done <= 1'b1;
					state <= jrle_idle;
				end
			endcase
		end
	end

	// ==========================================================
	// Checks
	sequence s_blk_start;
		state == jrle_idle && instr_valid && clk_en
			&& (opcode == `JRLE_OP_PMB_LD
			|| (opcode == `JRLE_OP_PMB_ST && HAS_EXT_PROG));
	endsequence

	a_jump_target: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE1]
		state == jrle_idle && instr_valid && clk_en && opcode[3:0] == `JRLE_NIB_JUMP
		|=> done && pc_load == $past(cond_true)
			&& pc_next == $past(pc) + {{8{$past(operand1[7])}}, $past(operand1)})
		else $error("relative jump target or take wrong");
	a_jump_always: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE4]
		state == jrle_idle && instr_valid && clk_en
		&& opcode == {`JRLE_CC_ALWAYS, `JRLE_NIB_JUMP} |=> pc_load)
		else $error("unconditional jump not taken");
	a_jump_cycles: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE1]
		pc_load |-> cycles == `JRLE_CYC_JR_TAKEN)
		else $error("taken jump cycle count wrong");
	a_move_done: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE5]
		state == jrle_wr && clk_en |=> rf_we && done && rf_waddr == $past(dst_addr))
		else $error("move did not write destination");
	a_short_full: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE6]
		state == jrle_idle && instr_valid && clk_en && opcode[3:0] == `JRLE_NIB_LD_W2R
		|=> dst_addr == $past(operand1))
		else $error("short store destination escaped");
	a_prog_guard: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE10]
		mem_req && mem_we |-> HAS_EXT_PROG || mem_space != jrle_mem_prog)
		else $error("program write on internal-only variant");
	a_data_guard: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE14]
		mem_req |-> HAS_EXT_DATA || mem_space != jrle_mem_data)
		else $error("external data access on unsupported variant");
	a_blk_cycles: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE11]
		s_blk_start |=> cycles == `JRLE_CYC_PMB)
		else $error("block move cycle count wrong");
	a_pm_cycles: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RULE9]
		state == jrle_idle && instr_valid && clk_en && opcode == `JRLE_OP_PM_LD
		|=> cycles == `JRLE_CYC_PM)
		else $error("program move cycle count wrong");
endmodule
`default_nettype wire

// >>> verif/jrle_mem_model.sv
// Memory partner: program and external data space behind one port
`timescale 1ns/1ps
`default_nettype none
module jrle_mem_model
(
	// Clock and answer delay
	input wire logic clk_sys,
	input wire logic [1:0] delay,
	// Memory port
	input wire logic mem_req,
	input wire logic mem_we,
	input wire jrle_pkg::jrle_mem_e mem_space,
	input wire jrle_pkg::jrle_addr_t mem_addr,
	input wire jrle_pkg::jrle_byte_t mem_wdata,
	output logic mem_ack,
	output jrle_pkg::jrle_byte_t mem_rdata
);
	import jrle_pkg::*;
	jrle_byte_t prog [0:65535];
	jrle_byte_t data [0:65535];
	logic [1:0] wait_cnt = 2'h0;
	initial mem_ack = 1'b0;
	initial mem_rdata = 8'h00;
	// ==========
	// Answer
	// Read data is good only with ack; it toggles otherwise so that a
	// late sample by the block shows up as wrong data
	always @(posedge clk_sys)
	begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack && wait_cnt != delay)
			wait_cnt <= wait_cnt + 2'h1;
		if (mem_req && !mem_ack && wait_cnt == delay)
		begin
			wait_cnt <= 2'h0;
			mem_ack <= 1'b1;
			mem_rdata <= (mem_space == jrle_mem_prog) ?
				prog[mem_addr] : data[mem_addr];
		end
		if (mem_req && mem_ack && mem_we && mem_space == jrle_mem_prog)
			prog[mem_addr] <= mem_wdata;
		if (mem_req && mem_ack && mem_we && mem_space == jrle_mem_data)
			data[mem_addr] <= mem_wdata;
	end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the relative-jump and move execution block
`timescale 1ns/1ps
`default_nettype none
`include "jrle_regs.svh"
module tb_top;
	import jrle_pkg::*;
	// ==========
	// Signals
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic instr_valid = 1'b0;
	jrle_byte_t opcode = 8'h00, operand1 = 8'h00, operand2 = 8'h00;
	jrle_addr_t pc = 16'h0000;
	jrle_byte_t flags = 8'h00;
	logic [3:0] wr_group = 4'h0;
	logic [1:0] delay = 2'h0;
	jrle_byte_t rf_raddr, rf_rdata, rf_waddr, rf_wdata, mem_wdata, mem_rdata;
	logic rf_we, mem_req, mem_we, mem_ack, pc_load, done, illegal;
	jrle_mem_e mem_space;
	jrle_addr_t mem_addr, pc_next, got_pc;
	logic [7:0] cycles, got_cyc;
	logic got_load, got_ill;
	logic lim_done, lim_ill;
	int lim_ill_cnt = 0;
	jrle_byte_t rf [0:255];
	jrle_byte_t xrf [0:255];
	int fails = 0;
	int samples_checked = 0;
	int seed = 32'h8938;
	always #2 clk_sys = ~clk_sys;
	// Register file with combinational read
	assign rf_rdata = rf[rf_raddr];
	always @(posedge clk_sys)
		if (rf_we)
			rf[rf_waddr] <= rf_wdata;
	jrle_exec #(.HAS_EXT_PROG(1'b1), .HAS_EXT_DATA(1'b1)) jrle_exec_inst
	(
		.clk_sys, .rst_b, .clk_en(1'b1), .instr_valid, .opcode, .operand1,
		.operand2, .pc, .flags, .wr_group, .rf_raddr, .rf_rdata, .rf_we,
		.rf_waddr, .rf_wdata, .mem_req, .mem_we, .mem_space, .mem_addr,
		.mem_wdata, .mem_ack, .mem_rdata, .pc_load, .pc_next, .done,
		.illegal, .cycles
	);
	jrle_mem_model jrle_mem_model_inst
	(
		.clk_sys, .delay, .mem_req, .mem_we, .mem_space, .mem_addr,
		.mem_wdata, .mem_ack, .mem_rdata
	);
	// Variant with neither external space; follows the main one step
	// for step on accepted work, so it can share its answers
	jrle_exec #(.HAS_EXT_PROG(1'b0), .HAS_EXT_DATA(1'b0)) jrle_exec_lim_inst
	(
		.clk_sys, .rst_b, .clk_en(1'b1), .instr_valid, .opcode, .operand1,
		.operand2, .pc, .flags, .wr_group, .rf_raddr(), .rf_rdata,
		.rf_we(), .rf_waddr(), .rf_wdata(), .mem_req(), .mem_we(),
		.mem_space(), .mem_addr(), .mem_wdata(), .mem_ack, .mem_rdata,
		.pc_load(), .pc_next(), .done(lim_done), .illegal(lim_ill),
		.cycles()
	);
	// Its refusals end early, so they are counted rather than sampled
	always @(posedge clk_sys)
		if (lim_done && lim_ill)
			lim_ill_cnt <= lim_ill_cnt + 1;
	// ==========
	// Helpers
	task automatic check(input string what, input logic [15:0] exp, got);
	begin
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	end
	endtask
	task automatic end_sim;
	begin
		if (fails == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	function automatic logic cond(input logic [3:0] c, input jrle_byte_t f);
		logic t;
	begin
		case (c[2:0])
			3'h0: t = 1'b0;
			3'h1: t = f[5] ^ f[4];
			3'h2: t = f[6] | (f[5] ^ f[4]);
			3'h3: t = f[7] | f[6];
			3'h4: t = f[4];
			3'h5: t = f[5];
			3'h6: t = f[6];
			default: t = f[7];
		endcase
		return t ^ c[3];
	end
	endfunction
	function automatic jrle_byte_t rsel(input logic [3:0] g,
		input jrle_byte_t b);
		return (b[7:4] == `JRLE_WR_ESC) ? {g, b[3:0]} : b;
	endfunction
	function automatic logic lim_refused(input jrle_byte_t op);
		return op == `JRLE_OP_PM_ST || op == `JRLE_OP_PMB_ST || op == 8'h83
			|| op == `JRLE_OP_XD_LD || op == `JRLE_OP_XD_ST;
	endfunction
	task automatic cpy;
	begin
		for (int k = 0; k < 256; k++)
			xrf[k] = rf[k];
	end
	endtask
	// Whole file compare also catches stray writes to sources
	task automatic cmp_rf;
		int k;
	begin
		k = 0;
		while (k < 255 && rf[k] === xrf[k])
			k++;
		check("rf", {k[7:0], xrf[k]}, {k[7:0], rf[k]});
	end
	endtask
	task automatic run(input jrle_byte_t op, o1, o2, input logic [3:0] g);
		int n;
		int c;
	begin
		n = 0;
		c = lim_ill_cnt;
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		opcode <= op;
		operand1 <= o1;
		operand2 <= o2;
		wr_group <= g;
		pc <= $random(seed);
		flags <= $random(seed);
		delay <= $random(seed);
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		#1;
		while (done !== 1'b1 && n < 99)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		check("done", 1'b1, done);
		check("illegal", op == 8'h83, illegal);
		got_load = pc_load;
		got_pc = pc_next;
		got_cyc = cycles;
		@(posedge clk_sys);
		#1;
		check("lim_illegal", lim_refused(op), lim_ill_cnt - c);
	end
	endtask
	initial
	begin
		#200000;
		fails++;
		end_sim;
	end
	// ==========
	// Main sequence
	initial
	begin : main
		jrle_byte_t v, b, d;
		jrle_byte_t ops [0:3];
		jrle_byte_t mv [0:6];
		logic [3:0] g, r, x;
		logic t;
		jrle_addr_t a;
		int rnd;
		for (int i = 0; i < 256; i++)
			rf[i] = $random(seed);
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		// Every condition, offsets at both ends of the signed range
		for (int i = 0; i < 48; i++)
		begin
			d = (i < 16) ? {i[0], {7{~i[0]}}} : $random(seed);
			cpy;
			run({i[3:0], `JRLE_NIB_JUMP}, d, 8'h00, i[7:4]);
			t = cond(i[3:0], flags);
			check("pc_load", t, got_load);
			if (t)
				check("pc_next", pc + {{8{d[7]}}, d}, got_pc);
			v = t ? `JRLE_CYC_JR_TAKEN : `JRLE_CYC_JR_NOT;
			check("cycles", v, got_cyc);
			cmp_rf;
		end
		for (int i = 0; i < 16; i++)
		begin
			rnd = $random(seed);
			g = rnd[3:0];
			r = i[3:0];
			v = rnd[15:8];
			b = (i < 4) ? {`JRLE_WR_ESC, ~r} : rnd[23:16];
			cpy;
			xrf[{g, r}] = v;
			run({r, `JRLE_NIB_LD_IMM}, v, 8'h00, g);
			cmp_rf;
			cpy;
			xrf[{g, r}] = xrf[(b[7:4] == `JRLE_WR_ESC) ? {g, b[3:0]} : b];
			run({r, `JRLE_NIB_LD_R2W}, b, 8'h00, g);
			cmp_rf;
			cpy;
			xrf[b] = xrf[{g, r}];
			run({r, `JRLE_NIB_LD_W2R}, b, 8'h00, g);
			cmp_rf;
			check("cycles", `JRLE_CYC_SHORT, got_cyc);
		end
		for (int i = 0; i < 8; i++)
		begin
			rnd = $random(seed);
			g = rnd[3:0];
			r = rnd[7:4];
			x = rnd[11:8];
			b = rnd[19:12];
			cpy;
			d = b + xrf[{g, x}];
			xrf[{g, r}] = xrf[d];
			run(`JRLE_OP_LD_XLD, {r, x}, b, g);
			cmp_rf;
			cpy;
			d = b + xrf[{g, x}];
			xrf[d] = xrf[{g, r}];
			run(`JRLE_OP_LD_XST, {r, x}, b, g);
			cmp_rf;
			check("cycles", `JRLE_CYC_LONG, got_cyc);
		end
		// Register and indirect moves, some operands in working form
		mv = '{`JRLE_OP_LD_WIW, `JRLE_OP_LD_IWW, `JRLE_OP_LD_RR,
			`JRLE_OP_LD_RIR, `JRLE_OP_LD_RIM, `JRLE_OP_LD_IRIM,
			`JRLE_OP_LD_IRR};
		for (int i = 0; i < 28; i++)
		begin
			rnd = $random(seed);
			g = rnd[3:0];
			b = i[3] ? {`JRLE_WR_ESC, rnd[7:4]} : rnd[11:4];
			d = i[2] ? {`JRLE_WR_ESC, rnd[15:12]} : rnd[23:16];
			v = mv[i % 7];
			cpy;
			case (v)
				`JRLE_OP_LD_WIW: xrf[{g, b[7:4]}] = xrf[xrf[{g, b[3:0]}]];
				`JRLE_OP_LD_IWW: xrf[xrf[{g, b[7:4]}]] = xrf[{g, b[3:0]}];
				`JRLE_OP_LD_RR: xrf[rsel(g, d)] = xrf[rsel(g, b)];
				`JRLE_OP_LD_RIR: xrf[rsel(g, d)] = xrf[xrf[rsel(g, b)]];
				`JRLE_OP_LD_RIM: xrf[rsel(g, b)] = d;
				`JRLE_OP_LD_IRIM: xrf[xrf[rsel(g, b)]] = d;
				default: xrf[xrf[rsel(g, d)]] = xrf[rsel(g, b)];
			endcase
			run(v, b, d, g);
			cmp_rf;
			d = (v[3:0] == 4'h3) ? `JRLE_CYC_SHORT : `JRLE_CYC_LONG;
			check("cycles", d, got_cyc);
		end
		// Memory moves in both directions and both spaces
		ops = '{`JRLE_OP_PM_LD, `JRLE_OP_PM_ST, `JRLE_OP_XD_LD, `JRLE_OP_XD_ST};
		for (int i = 0; i < 16; i++)
		begin
			rnd = $random(seed);
			g = rnd[3:0];
			r = rnd[7:4];
			x = {rnd[11:9], 1'b0};
			v = rnd[23:16];
			b = ops[i % 4];
			cpy;
			a = {xrf[{g, x}], xrf[{g, x | 4'h1}]};
			if (b[4] == 1'b0)
				xrf[{g, r}] = v;
			if (b == `JRLE_OP_PM_LD)
				jrle_mem_model_inst.prog[a] = v;
			if (b == `JRLE_OP_XD_LD)
				jrle_mem_model_inst.data[a] = v;
			run(b, {r, x}, 8'h00, g);
			cmp_rf;
			v = b[6] ? jrle_mem_model_inst.prog[a] : jrle_mem_model_inst.data[a];
			if (b[4])
				check("mem", xrf[{g, r}], v);
			v = b[6] ? `JRLE_CYC_PM : `JRLE_CYC_XD;
			check("cycles", v, got_cyc);
		end
		// Block moves; the first two carry out of the low pointer byte
		for (int i = 0; i < 8; i++)
		begin
			rnd = $random(seed);
			g = rnd[3:0];
			x = {rnd[7:5], 1'b0};
			r = {rnd[7:5] ^ 3'h2, rnd[8]};
			rf[{g, r}] = {~g, rnd[15:12]};
			if (i < 2)
				rf[{g, x | 4'h1}] = 8'hFF;
			cpy;
			a = {xrf[{g, x}], xrf[{g, x | 4'h1}]};
			b = i[0] ? `JRLE_OP_PMB_ST : `JRLE_OP_PMB_LD;
			jrle_mem_model_inst.prog[a] = rnd[23:16];
			if (!i[0])
				xrf[xrf[{g, r}]] = rnd[23:16];
			v = xrf[xrf[{g, r}]];
			xrf[{g, r}] = xrf[{g, r}] + 8'h01;
			{xrf[{g, x}], xrf[{g, x | 4'h1}]} = a + 16'h0001;
			run(b, {r, x}, 8'h00, g);
			cmp_rf;
			check("mem", v, jrle_mem_model_inst.prog[a]);
			check("cycles", `JRLE_CYC_PMB, got_cyc);
		end
		// An opcode outside the group must leave everything alone
		cpy;
		run(8'h83, 8'h26, 8'h00, 4'h1);
		cmp_rf;
		end_sim;
	end
endmodule
`default_nettype wire
